// File: bus_master_header_query.sv
// Command interpreter answering the module header and clear counters requests.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module bus_master_header_query
   import header_query_pkg::*;
#(
   parameter int MEM_DEPTH = 256,
   parameter int CNT_W     = 16
) (
   input  wire logic                        clk_i,              // Clock.
   input  wire logic                        rst_n_i,            // Reset.
   input  wire logic [11:0]                 avs_address_i,      // Byte addr.
   input  wire logic                        avs_read_i,         // Read.
   input  wire logic                        avs_write_i,        // Write.
   input  wire logic [31:0]                 avs_writedata_i,    // Wr data.
   input  wire logic [3:0]                  avs_byteenable_i,   // Lanes.
   output logic      [31:0]                 avs_readdata_o,     // Rd data.
   output logic                             avs_waitrequest_o,  // Stall.
   input  wire header_query_pkg::node_state_t node_state_i,     // Node state.
   input  wire logic [NUM_COUNTERS-1:0]     stat_event_i,       // Events.
   output logic                             busy_o              // Busy.
);
   import header_query_pkg::*;

   // The shared memory window holds at most 256 words on the bus map.
   if (MEM_DEPTH < 32 || MEM_DEPTH > 256)
      $error("MEM_DEPTH must lie between 32 and 256");
   if (CNT_W < 1 || CNT_W > 16)
      $error("CNT_W must lie between 1 and 16");

   logic [15:0]      req  [REQ_WORDS];
   logic [15:0]      mem  [MEM_DEPTH];
   logic [15:0]      snap [20];
   logic [CNT_W-1:0] cnt  [NUM_COUNTERS];
   fsm_state_t       state;
   logic [4:0]       idx;
   logic [4:0]       reply_last;
   logic [16:0]      reply_base;
   logic [16:0]      stat_idx;
   logic [15:0]      status_word;
   logic             is_header;

   function automatic logic type_ok(input logic [15:0] t);
      return (t == MT_WORD) || (t == MT_BYTE) || (t == MT_BIT);
   endfunction

   // Offsets count bits, bytes or words; all are turned into word indices.
   function automatic logic [16:0] to_word(input logic [15:0] t,
                                           input logic [15:0] ofs);
      logic [16:0] w;
      w = {1'b0, ofs};
      if (t == MT_BYTE)
         w = {2'b00, ofs[15:1]};
      else if (t == MT_BIT)
         w = {5'b00000, ofs[15:4]};
      return w;
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   // Bus decode. The slave answers one cycle after it sees a request; non-control accesses also wait until the command has ended.
   logic       bus_req;
   logic       hit_req;
   logic       hit_ctrl;
   logic       hit_mem;
   logic       serve;
   logic       exec;
   logic       start;
   logic [7:0] mem_bus_idx;

   assign bus_req     = avs_read_i | avs_write_i;
   assign hit_req     = avs_address_i[11:2] < 10'(REQ_WORDS);
   assign hit_ctrl    = avs_address_i == CTRL_ADDR;
   assign mem_bus_idx = avs_address_i[9:2];
   assign hit_mem     = (avs_address_i[11:10] == MEM_PAGE) &&
                        (9'(mem_bus_idx) < 9'(MEM_DEPTH));
   // Request and memory words are closed to the bus while a command runs.
   assign serve = bus_req && avs_waitrequest_o &&
                  (hit_ctrl || state == ST_IDLE);
   assign exec  = bus_req && !avs_waitrequest_o;
   assign start = exec && avs_write_i && hit_ctrl && avs_byteenable_i[0] &&
                  avs_writedata_i[CTRL_START] && state == ST_IDLE;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !serve;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (serve && avs_read_i) begin
         if (hit_ctrl)
            avs_readdata_o <= {status_word, 15'h0000, busy_o};
         else if (hit_req)
            avs_readdata_o <= {16'h0000, req[avs_address_i[5:2]]};
         else if (hit_mem)
            avs_readdata_o <= {16'h0000, mem[mem_bus_idx]};
         else
            avs_readdata_o <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < REQ_WORDS; i++)
            req[i] <= 16'h0000;
      end else if (exec && avs_write_i && hit_req) begin
         req[avs_address_i[5:2]] <= merge(req[avs_address_i[5:2]],
                                          avs_writedata_i, avs_byteenable_i);
      end
   end

   // Request check, evaluated in the check state.
   logic        hdr_code;
   logic        clr_code;
   logic        req_ok;
   logic        area_ok;
   logic        stat_ok;
   logic [4:0]  need;
   logic [15:0] need_units;
   logic [16:0] base_w;
   logic [16:0] sidx_w;
   logic [15:0] next_status;
   logic        clear_now;

   assign hdr_code   = req[REQ_CODE_IDX] == CODE_HEADER;
   assign clr_code   = req[REQ_CODE_IDX] == CODE_CLEAR;
   assign req_ok     = req[REQ_LEN_IDX] == REQ_LEN_VAL &&
                       req[REQ_WAIT_IDX] == NO_WAIT_VAL;
   assign need       = hdr_code ? HDR_WORDS : CLR_WORDS;
   assign need_units = (req[REQ_RTYPE_IDX] == MT_WORD) ?
                       16'(need) : 16'({need, 1'b0});
   assign base_w     = to_word(req[REQ_RTYPE_IDX], req[REQ_ROFS_IDX]);
   assign sidx_w     = 17'(to_word(req[REQ_STYPE_IDX], req[REQ_SOFS_IDX])
                           + 17'h00001);
   assign stat_ok    = type_ok(req[REQ_STYPE_IDX]) &&
                       sidx_w < 17'(MEM_DEPTH);
   // A clear answer area larger than its two words fails the command.
   assign area_ok    = type_ok(req[REQ_RTYPE_IDX]) && stat_ok &&
                       (hdr_code ? req[REQ_RSIZE_IDX] >= need_units
                                 : req[REQ_RSIZE_IDX] == need_units) &&
                       18'(base_w) + 18'(need) <= 18'(MEM_DEPTH);

   always_comb begin
      if (!req_ok)
         next_status = STAT_BAD_REQ;
      else if (!(hdr_code || clr_code))
         next_status = STAT_BAD_CMD;
      else if (!area_ok)
         next_status = STAT_BAD_AREA;
      else
         next_status = STAT_OK;
   end

   assign clear_now = state == ST_CHECK && clr_code && next_status == STAT_OK;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state       <= ST_IDLE;
         idx         <= 5'h00;
         reply_last  <= 5'h00;
         reply_base  <= 17'h00000;
         stat_idx    <= 17'h00000;
         status_word <= 16'h0000;
         is_header   <= 1'b0;
         busy_o      <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  state  <= ST_CHECK;
                  busy_o <= 1'b1;
               end
            end
            ST_CHECK: begin
               idx         <= 5'h00;
               reply_last  <= 5'(need - 5'h01);
               reply_base  <= base_w;
               stat_idx    <= sidx_w;
               status_word <= next_status;
               is_header   <= hdr_code;
               if (next_status == STAT_OK) begin
                  state <= ST_REPLY;
               end else if (stat_ok) begin
                  state <= ST_STAT;
               end else begin
                  state  <= ST_IDLE;
                  busy_o <= 1'b0;
               end
            end
            ST_REPLY: begin
               idx <= 5'(idx + 5'h01);
               if (idx == reply_last)
                  state <= ST_STAT;
            end
            ST_STAT: begin
               state  <= ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

   // The reply is frozen at check time so that it is one consistent picture.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 20; i++)
            snap[i] <= 16'h0000;
      end else if (state == ST_CHECK) begin
         if (hdr_code) begin
            snap[0] <= CODE_HEADER;
            snap[1] <= node_state_i.role_master ? ROLE_MASTER
                                                : ROLE_SLAVE;
            snap[2] <= node_state_i.fw_rev;
            snap[3] <= {node_state_i.shm_state,
                        node_state_i.global_state};
            snap[4] <= {(node_state_i.err_src != 8'h00) ?
                        node_state_i.err_code : 8'h00,
                        node_state_i.err_src};
            for (int k = 0; k < NUM_COUNTERS; k++)
               snap[CNT_FIRST_WORD + k] <= 16'(cnt[k]);
            snap[18] <= node_state_i.exch_time_ms;
            snap[19] <= 16'h0000;
         end else begin
            snap[0] <= CODE_CLEAR;
            snap[1] <= CLEAR_OK;
         end
      end
   end

   // Counter k follows event bit k; an event in the clearing cycle counts.
   for (genvar k = 0; k < NUM_COUNTERS; k++) begin : g_cnt
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i)
            cnt[k] <= '0;
         else if (clear_now)
            cnt[k] <= CNT_W'(stat_event_i[k]);
         else if (stat_event_i[k])
            cnt[k] <= CNT_W'(cnt[k] + 1'b1);
      end
   end

   logic [7:0] reply_idx;
   assign reply_idx = 8'(reply_base + 17'(idx));

   always_ff @(posedge clk_i) begin
      if (state == ST_REPLY)
         mem[reply_idx] <= snap[idx];
      else if (state == ST_STAT)
         mem[stat_idx[7:0]] <= status_word;
      else if (exec && avs_write_i && hit_mem)
         mem[mem_bus_idx] <= merge(mem[mem_bus_idx], avs_writedata_i,
                                   avs_byteenable_i);
   end

   // Checks.
   logic [5:0] wait_cnt;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         wait_cnt <= 6'h00;
      else if (state == ST_REPLY)
         wait_cnt <= 6'(wait_cnt + 6'h01);
      else
         wait_cnt <= 6'h00;
   end

   chk_status_last: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(state == ST_STAT) && $past(state) == ST_REPLY
         |-> wait_cnt == 6'(reply_last) + 6'h01)
      else $error("status written before reply complete");

   chk_echo_code: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_REPLY && idx == 5'h00 && is_header
         |-> snap[0] == CODE_HEADER ##1 mem[$past(reply_idx)] == CODE_HEADER)
      else $error("reply word one is not the echoed code");

   chk_role_word: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_CHECK && hdr_code |=> snap[1] ==
         ($past(node_state_i.role_master) ? ROLE_MASTER : ROLE_SLAVE))
      else $error("interface role word wrong");

   chk_err_code: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_REPLY && is_header && snap[4][7:0] == 8'h00
         |-> snap[4][15:8] == 8'h00)
      else $error("error code present with zero source");

   chk_counter_clear: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      clear_now |=> cnt[0] == CNT_W'($past(stat_event_i[0])) &&
                    cnt[12] == CNT_W'($past(stat_event_i[12])))
      else $error("counters not cleared");

   chk_count_inc: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      stat_event_i[0] && !clear_now |=> cnt[0] == CNT_W'($past(cnt[0]) + 1'b1))
      else $error("bus fault count did not advance");

   chk_status_addr: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_CHECK && stat_ok
         |=> stat_idx == $past(to_word(req[REQ_STYPE_IDX],
                                       req[REQ_SOFS_IDX])) + 17'h00001)
      else $error("status word location wrong");

   chk_reply_base: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_CHECK && next_status == STAT_OK
         |=> state == ST_REPLY && reply_idx == 8'($past(base_w)))
      else $error("reply not placed at requested offset");

   chk_bus_answer: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      bus_req && avs_waitrequest_o |-> ##[0:25] !avs_waitrequest_o)
      else $error("bus request never answered");

   chk_fw_word: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_CHECK && hdr_code |=> snap[2] == $past(node_state_i.fw_rev))
      else $error("firmware revision word wrong");

   chk_clear_reply: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      clear_now |=> snap[0] == CODE_CLEAR && snap[1] == CLEAR_OK)
      else $error("clear reply words wrong");

   chk_time_word: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_CHECK && hdr_code
         |=> snap[18] == $past(node_state_i.exch_time_ms) &&
             snap[19] == 16'h0000)
      else $error("exchange time word wrong");

   cov_header_done: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_STAT && is_header && status_word == STAT_OK);
   cov_clear_done: cover property (
      @(posedge clk_i) disable iff (!rst_n_i) clear_now);
   cov_bad_area: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      state == ST_STAT && status_word == STAT_BAD_AREA);
   cov_mem_read: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      exec && avs_read_i && hit_mem);

endmodule

// File: bus_master_header_query_tb_top.sv
// Self-checking testbench of the module header query block.
`timescale 1ns/1ps
module bus_master_header_query_tb_top;
   import header_query_pkg::*;

   localparam logic [15:0] FW = 16'h0203;
   localparam logic [7:0]  GL = 8'h5a;
   localparam logic [7:0]  SH = 8'ha5;
   localparam logic [7:0]  EC = 8'h21;
   localparam logic [15:0] XT = 16'h0123;

   logic                    clk_i = 1'b0;
   logic                    rst_n_i = 1'b0;
   logic [11:0]             avs_address_i = 12'h000;
   logic                    avs_read_i = 1'b0;
   logic                    avs_write_i = 1'b0;
   logic [31:0]             avs_writedata_i = 32'h0;
   logic [31:0]             avs_readdata_o;
   logic                    avs_waitrequest_o;
   node_state_t             node_state;
   logic [NUM_COUNTERS-1:0] stat_event;
   logic [NUM_COUNTERS-1:0] fire = '0;
   logic                    master = 1'b1;
   logic [7:0]              err_src = 8'hff;
   logic                    busy_o;
   logic [15:0]             req [REQ_WORDS];
   logic [15:0]             s_type = MT_WORD;
   logic [15:0]             cnt [NUM_COUNTERS];
   int                      error_cnt = 0;
   int                      samples_checked = 0;
   int                      cyc = 0;

   always #5 clk_i = ~clk_i;

   bus_master_header_query #(.MEM_DEPTH(256), .CNT_W(16)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .node_state_i(node_state), .stat_event_i(stat_event), .busy_o(busy_o));

   net_stats_model #(.FW_REV(FW), .GLOB(GL), .SHM(SH), .ECODE(EC),
                     .XTIME(XT)) peer (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .master_i(master),
      .err_src_i(err_src), .node_state_o(node_state),
      .stat_event_o(stat_event));

   task automatic end_of_test;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Ceiling sits far above the less than one thousand cycles the sequence needs.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // One bus transfer, held until waitrequest is sampled low.
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [15:0] d, output logic [31:0] q);
      @(posedge clk_i);
      avs_read_i      <= !w;
      avs_write_i     <= w;
      avs_address_i   <= a;
      avs_writedata_i <= {16'h0000, d};
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rd_mem(input int idx, output logic [15:0] w);
      logic [31:0] q;
      acc(1'b0, 12'h400 + 12'(4 * idx), 16'h0000, q);
      w = q[15:0];
   endtask

   task automatic run(input logic [15:0] len, input logic [15:0] wt,
                      input logic [15:0] code, input logic [15:0] rt,
                      input logic [15:0] ro, input logic [15:0] rs,
                      input logic [15:0] so, input logic [15:0] st);
      logic [31:0] q;
      logic [15:0] w;
      int          n;
      req = '{len, wt, s_type, so, 16'h0000, 16'h0000, code, rt, ro, rs};
      for (int i = 0; i < REQ_WORDS; i++) begin
         acc(1'b1, 12'(4 * i), req[i], q);
      end
      acc(1'b1, CTRL_ADDR, 16'h0001, q);
      n = 0;
      do begin
         acc(1'b0, CTRL_ADDR, 16'h0000, q);
         n++;
      end while (q[0] !== 1'b0 && n < 50);
      chk({15'h0000, q[0]}, 16'h0000);
      chk({15'h0000, busy_o}, 16'h0000);
      chk(q[31:16], st);
      // Byte offsets of the status word are halved to a word index.
      rd_mem(((s_type == MT_BYTE) ? int'(so) / 2 : int'(so)) + 1, w);
      chk(w, st);
   endtask

   task automatic hdr_chk(input int base);
      logic [15:0] w;
      for (int i = 0; i < 20; i++) begin
         rd_mem(base + i, w);
         case (i)
            0: chk(w, CODE_HEADER);
            1: chk(w, master ? ROLE_MASTER : ROLE_SLAVE);
            2: chk(w, FW);
            3: chk(w, {SH, GL});
            4: chk(w, {(err_src != 8'h00) ? EC : 8'h00, err_src});
            18: chk(w, XT);
            19: chk(w, 16'h0000);
            default: chk(w, cnt[i - 5]);
         endcase
      end
   endtask

   initial begin
      logic [31:0] q;
      logic [15:0] w;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      acc(1'b0, CTRL_ADDR, 16'h0000, q);
      chk(q[15:0], 16'h0000);
      acc(1'b0, 12'h300, 16'h0000, q);
      chk(q[15:0], 16'h0000);
      // Counter k sees k+1 pulses, so every word has a distinct value.
      for (int n = 0; n < NUM_COUNTERS; n++) begin
         @(posedge clk_i);
         fire <= 13'h1fff << n;
         cnt[n] = 16'(n + 1);
      end
      @(posedge clk_i);
      fire <= '0;
      repeat (3) @(posedge clk_i);
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_HEADER, MT_WORD, 16'd40, 16'd20,
          16'd200, STAT_OK);
      hdr_chk(40);
      master  <= 1'b0;
      err_src <= 8'h00;
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_HEADER, MT_BYTE, 16'd200, 16'd40,
          16'd201, STAT_OK);
      hdr_chk(100);
      err_src <= 8'h07;
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_HEADER, MT_BIT, 16'd2240, 16'd40,
          16'd202, STAT_OK);
      hdr_chk(140);
      s_type = MT_BYTE;
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_CLEAR, MT_WORD, 16'd80, 16'd2,
          16'd406, STAT_OK);
      s_type = MT_WORD;
      rd_mem(80, w);
      chk(w, CODE_CLEAR);
      rd_mem(81, w);
      chk(w, CLEAR_OK);
      for (int k = 0; k < NUM_COUNTERS; k++) begin
         cnt[k] = 16'h0000;
      end
      master <= 1'b1;
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_HEADER, MT_WORD, 16'd120, 16'd20,
          16'd204, STAT_OK);
      hdr_chk(120);
      run(16'h0005, NO_WAIT_VAL, CODE_HEADER, MT_WORD, 16'd160, 16'd20,
          16'd205, STAT_BAD_REQ);
      run(REQ_LEN_VAL, 16'h0001, CODE_HEADER, MT_WORD, 16'd160, 16'd20,
          16'd206, STAT_BAD_REQ);
      run(REQ_LEN_VAL, NO_WAIT_VAL, 16'h0009, MT_WORD, 16'd160, 16'd20,
          16'd207, STAT_BAD_CMD);
      run(REQ_LEN_VAL, NO_WAIT_VAL, CODE_HEADER, MT_WORD, 16'd160, 16'd19,
          16'd208, STAT_BAD_AREA);
      end_of_test();
   end
endmodule

// File: header_query_pkg.sv
// Constants, field layouts and types shared by the module header query block.
package header_query_pkg;

   // Request block layout, as word indices from zero.
   localparam int REQ_WORDS       = 10;
   localparam int REQ_LEN_IDX     = 0;
   localparam int REQ_WAIT_IDX    = 1;
   localparam int REQ_STYPE_IDX   = 2;
   localparam int REQ_SOFS_IDX    = 3;
   localparam int REQ_CODE_IDX    = 6;
   localparam int REQ_RTYPE_IDX   = 7;
   localparam int REQ_ROFS_IDX    = 8;
   localparam int REQ_RSIZE_IDX   = 9;

   localparam logic [15:0] REQ_LEN_VAL   = 16'h0004;
   localparam logic [15:0] NO_WAIT_VAL   = 16'h0000;
   localparam logic [15:0] CODE_HEADER   = 16'h0005;
   localparam logic [15:0] CODE_CLEAR    = 16'h0006;
   localparam logic [15:0] ROLE_MASTER   = 16'h0002;
   localparam logic [15:0] ROLE_SLAVE    = 16'h0001;
   localparam logic [7:0]  ERR_SRC_SELF  = 8'hff;
   localparam logic [7:0]  ERR_SRC_MAX   = 8'h7d;
   localparam logic [15:0] CLEAR_OK      = 16'h0001;

   // Reply lengths in words.
   localparam logic [4:0]  HDR_WORDS     = 5'h14;
   localparam logic [4:0]  CLR_WORDS     = 5'h02;

   // Memory type codes of the host memory areas.
   localparam logic [15:0] MT_WORD       = 16'h0008;
   localparam logic [15:0] MT_BYTE       = 16'h000a;
   localparam logic [15:0] MT_BIT        = 16'h0046;

   // Completion status word values.
   localparam logic [15:0] STAT_OK       = 16'h0001;
   localparam logic [15:0] STAT_BAD_REQ  = 16'h0002;
   localparam logic [15:0] STAT_BAD_CMD  = 16'h0003;
   localparam logic [15:0] STAT_BAD_AREA = 16'h0007;

   // Byte addresses on the register bus, the memory page select and control register bit positions.
   localparam logic [11:0] CTRL_ADDR     = 12'h028;
   localparam logic [1:0]  MEM_PAGE      = 2'h1;
   localparam int          CTRL_START    = 0;
   localparam int          CTRL_BUSY     = 0;
   localparam int          CTRL_STAT_LSB = 16;

   // Statistics counters feed reply words six through eighteen.
   localparam int NUM_COUNTERS   = 13;
   localparam int CNT_FIRST_WORD = 5;

   typedef struct packed {
      logic        role_master;   // Module runs as bus master.
      logic [15:0] fw_rev;        // Major in high byte, minor in low byte.
      logic [7:0]  global_state;  // Global state bits of the master.
      logic [7:0]  shm_state;     // shared_memory_control_state.
      logic [7:0]  err_src;       // Station that caused the last error.
      logic [7:0]  err_code;      // Error event code.
      logic [15:0] exch_time_ms;  // exchange_time_ms.
   } node_state_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_REPLY = 2'b11,
      ST_STAT  = 2'b10
   } fsm_state_t;

endpackage

// File: net_stats_model.sv
// Behavioural model of the network side feeding node state and statistics.
`timescale 1ns/1ps
module net_stats_model
   import header_query_pkg::*;
#(
   parameter logic [15:0] FW_REV = 16'h0203, // Arbitrary revision value.
   parameter logic [7:0]  GLOB   = 8'h5a,
   parameter logic [7:0]  SHM    = 8'ha5,
   parameter logic [7:0]  ECODE  = 8'h21,
   parameter logic [15:0] XTIME  = 16'h0123
) (
   input  wire logic                          clk_i,         // Clock.
   input  wire logic                          rst_n_i,       // Reset.
   input  wire logic [NUM_COUNTERS-1:0]       fire_i,        // Events.
   input  wire logic                          master_i,      // Master role.
   input  wire logic [7:0]                    err_src_i,     // Error station.
   output header_query_pkg::node_state_t      node_state_o,  // Node state.
   output logic      [NUM_COUNTERS-1:0]       stat_event_o   // Event pulses.
);
   import header_query_pkg::*;

   // Each requested event is registered on the same clock, one cycle later, for as long as it is held.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_event_o <= '0;
      end else begin
         stat_event_o <= fire_i;
      end
   end

   // The error source is only ever a station 0..125 or the master itself.
   assign node_state_o = '{master_i, FW_REV, GLOB, SHM,
      (err_src_i > ERR_SRC_MAX) ? ERR_SRC_SELF : err_src_i,
      ECODE, XTIME};
endmodule
